// file: src/serial_channel.sv
// serial channel: format/control registers, transmitter, receiver
`timescale 1ns/1ps
`default_nettype none
module serial_channel
  import serial_cfg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       standby,
  input  wire logic [2:0] cpu_addr,
  input  wire logic       cpu_wr,
  input  wire logic       cpu_rd,
  input  wire logic [7:0] cpu_wdata,
  output logic      [7:0] cpu_rdata,
  input  wire logic       rxd,
  output logic            txd,
  output logic            sck_out,
  output logic            sck_oe,
  output logic            tx_empty_irq,
  output logic            rx_irq
);
  import serial_cfg_pkg::*;

  logic [7:0]  serial_format_reg;
  logic [7:0]  serial_ctrl_reg;
  logic [7:0]  tx_holding_reg;
  logic [7:0]  serial_status_reg;
  logic [7:0]  rd_armed;
  logic [5:0]  presc;
  logic        tick;
  logic        rxd_meta;
  logic        rxd_s;
  tx_state_t   tx_state;
  logic [11:0] tx_shift_reg;
  logic [3:0]  tx_left;
  logic [7:0]  tx_cnt;
  logic        tx_load;
  logic        tx_done;
  rx_state_t   rx_state;
  logic [11:0] rx_bits;
  logic [3:0]  rx_idx;
  logic [7:0]  rx_cnt;
  logic        rx_end;
  logic        sync_rx_take;
  logic [7:0]  rx_char;
  logic        rx_extra;
  logic        rx_par_err;
  logic        rx_frm_err;
  logic        rx_push;
  logic        wr_status;
  logic        rd_rxdata;

  wire sync_mode  = serial_format_reg[FMT_SYNC];
  wire chr7       = serial_format_reg[FMT_CHR7] && !sync_mode;
  wire mp_fmt     = serial_format_reg[FMT_MP] && !sync_mode;
  wire par_on     = serial_format_reg[FMT_PE] && !sync_mode
                    && !mp_fmt;
  wire odd_sense  = serial_format_reg[FMT_ODD];
  wire stop2      = serial_format_reg[FMT_STOP2] && !sync_mode;
  wire tx_en      = serial_ctrl_reg[CTL_TE];
  wire rx_en      = serial_ctrl_reg[CTL_RE];
  wire tx_holding_empty_flag       = serial_status_reg[ST_TX_HOLDING_EMPTY_FLAG];

  stream_if #(.WIDTH(RXQ_WIDTH)) rxq_in ();
  stream_if #(.WIDTH(RXQ_WIDTH)) rxq_out ();

  stream_fifo #(.WIDTH(RXQ_WIDTH), .DEPTH(RXQ_DEPTH)) rx_queue (
    .clk   (clk),
    .rst_n (rst_n),
    .fill  (rxq_in),
    .drain (rxq_out)
  );

  // tick every 1, 4, 16 or 64 clocks
  function automatic logic presc_tick(input logic [1:0] sel,
                                      input logic [5:0] cnt);
    case (sel)
      2'h0:    presc_tick = 1'b1;
      2'h1:    presc_tick = (cnt[1:0] == 2'h3);
      2'h2:    presc_tick = (cnt[3:0] == 4'hf);
      default: presc_tick = (cnt == 6'h3f);
    endcase
  endfunction

  // parity bit that gives the chosen sense over the character
  function automatic logic parity_of(input logic [7:0] d,
                                     input logic       odd);
    parity_of = ^d ^ odd;
  endfunction

  // bits of one character frame, lsb first, and their count
  function automatic logic [15:0] build_frame(input logic [7:0] d,
                                              input logic sy,
                                              input logic c7,
                                              input logic pe,
                                              input logic od,
                                              input logic mp,
                                              input logic mpb,
                                              input logic s2);
    logic [11:0] f;
    logic [3:0]  n;
    f = '1;
    n = 4'd0;
    if (sy) begin
      f[7:0] = d;
      n      = LEN_SYNC;
    end else begin
      f[0] = 1'b0;
      f[7:1] = d[6:0];
      n = c7 ? 4'd8 : 4'd9;
      if (!c7) begin
        f[8] = d[7];
      end
      if (mp) begin
        f[n] = mpb;
        n = n + 4'd1;
      end else if (pe) begin
        f[n] = parity_of(c7 ? {1'b0, d[6:0]} : d, od);
        n = n + 4'd1;
      end
      n = n + (s2 ? 4'd2 : 4'd1);
    end
    build_frame = {n, f};
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc <= '0;
    end else begin
      presc <= presc + 6'd1;
    end
  end
  assign tick = presc_tick(serial_format_reg[FMT_CKS_LO +: 2], presc);

  // pin synchroniser, second stage is the only reader of the first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_meta <= 1'b1;
      rxd_s    <= 1'b1;
    end else begin
      rxd_meta <= rxd;
      rxd_s    <= rxd_meta;
    end
  end

  assign wr_status = cpu_wr && (cpu_addr == OFS_STATUS);
  assign rd_rxdata = cpu_rd && (cpu_addr == OFS_RXDATA);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_format_reg <= FORMAT_RST;
      serial_ctrl_reg   <= CTRL_RST;
      tx_holding_reg    <= TXHOLD_RST;
    end else if (standby) begin
      serial_format_reg <= FORMAT_RST;
      serial_ctrl_reg   <= CTRL_RST;
      tx_holding_reg    <= TXHOLD_RST;
    end else if (cpu_wr) begin
      case (cpu_addr)
        OFS_FORMAT: serial_format_reg <= cpu_wdata;
        OFS_CTRL:   serial_ctrl_reg   <= cpu_wdata;
        OFS_TXHOLD: tx_holding_reg    <= cpu_wdata;
        default:    ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rdata <= '0;
    end else if (cpu_rd) begin
      case (cpu_addr)
        OFS_FORMAT: cpu_rdata <= serial_format_reg;
        OFS_CTRL:   cpu_rdata <= serial_ctrl_reg;
        OFS_TXHOLD: cpu_rdata <= tx_holding_reg;
        OFS_STATUS: cpu_rdata <= serial_status_reg;
        OFS_RXDATA: cpu_rdata <= rxq_out.valid ? rxq_out.data : RDATA_RST;
        default:    cpu_rdata <= '0;
      endcase
    end
  end
  assign rxq_out.ready = rd_rxdata;

  // a flag in ST_CLEARABLE clears only on a zero write after it was read as one; TEND clears with TDRE, RDRF follows the receive buffer;
  // hardware set wins over the clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_status_reg <= STATUS_RST;
      rd_armed          <= '0;
    end else if (standby) begin
      serial_status_reg <= STATUS_RST;
      rd_armed          <= '0;
    end else begin
      if (cpu_rd && cpu_addr == OFS_STATUS) begin
        rd_armed <= serial_status_reg & ST_CLEARABLE;
      end
      for (int i = 0; i < 8; i++) begin
        if (wr_status && rd_armed[i] && !cpu_wdata[i]) begin
          serial_status_reg[i] <= 1'b0;
          rd_armed[i] <= 1'b0;
        end
      end
      if (wr_status && rd_armed[ST_TX_HOLDING_EMPTY_FLAG] && !cpu_wdata[ST_TX_HOLDING_EMPTY_FLAG]) begin
        serial_status_reg[ST_TEND] <= 1'b0;
      end
      if (wr_status) begin
        serial_status_reg[ST_MPBT] <= cpu_wdata[ST_MPBT];
      end
      serial_status_reg[ST_RDRF] <= rxq_out.valid;
      if (tx_load || !tx_en) begin
        serial_status_reg[ST_TX_HOLDING_EMPTY_FLAG] <= 1'b1;
      end
      if (tx_done && tx_holding_empty_flag) begin
        serial_status_reg[ST_TEND] <= 1'b1;
      end
      if (rx_push && !rxq_in.ready) begin
        serial_status_reg[ST_ORER] <= 1'b1;
      end
      if (rx_end && rx_frm_err) begin
        serial_status_reg[ST_FER] <= 1'b1;
      end
      if (rx_end && rx_par_err) begin
        serial_status_reg[ST_PER] <= 1'b1;
      end
      if (rx_end && mp_fmt) begin
        serial_status_reg[ST_MPB] <= rx_extra;
      end
    end
  end

  assign tx_load = (tx_state == TX_IDLE) && tx_en && !tx_holding_empty_flag;
  assign tx_done = (tx_state == TX_SHIFT) && tick
                   && (tx_cnt == BIT_TICKS - 8'd1) && (tx_left == 4'd1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state     <= TX_IDLE;
      tx_shift_reg <= '1;
      tx_left      <= '0;
      tx_cnt       <= '0;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          if (tx_load) begin
            {tx_left, tx_shift_reg} <= build_frame(tx_holding_reg,
              sync_mode, chr7, par_on, odd_sense, mp_fmt,
              serial_status_reg[ST_MPBT], stop2);
            tx_cnt   <= '0;
            tx_state <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (tick) begin
            if (tx_cnt == BIT_TICKS - 8'd1) begin
              tx_cnt       <= '0;
              tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
              tx_left      <= tx_left - 4'd1;
              if (tx_left == 4'd1) begin
                tx_state <= TX_IDLE;
              end
            end else begin
              tx_cnt <= tx_cnt + 8'd1;
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  assign txd          = (tx_state == TX_SHIFT) ? tx_shift_reg[0] : 1'b1;
  assign sck_oe       = sync_mode;
  assign sck_out      = !((tx_state == TX_SHIFT) && (tx_cnt < HALF_TICKS));
  assign tx_empty_irq = serial_ctrl_reg[CTL_TIE] && tx_holding_empty_flag;
  assign rx_irq       = serial_ctrl_reg[CTL_RIE] && (rxq_out.valid
                        || |serial_status_reg[ST_ORER:ST_PER]);

  // sync receive samples on the rising edge of the clock that we drive
  assign sync_rx_take = sync_mode && rx_en && (tx_state == TX_SHIFT)
                        && tick && (tx_cnt == HALF_TICKS - 8'd1);
  wire [3:0] rx_data_len = chr7 ? 4'd7 : 4'd8;
  wire [3:0] rx_last     = rx_data_len + ((par_on || mp_fmt) ? 4'd1 : 4'd0);
  wire       async_take  = (rx_state == RX_DATA) && tick
                           && (rx_cnt == BIT_TICKS - 8'd1);
  assign rx_end = sync_mode ? (sync_rx_take && rx_idx == LEN_SYNC - 4'd1)
                            : (async_take && rx_idx == rx_last);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state <= RX_IDLE;
      rx_bits  <= '0;
      rx_idx   <= '0;
      rx_cnt   <= '0;
    end else if (!rx_en || sync_mode) begin
      rx_state <= RX_IDLE;
      rx_cnt   <= '0;
      if (sync_rx_take) begin
        rx_bits[rx_idx] <= rxd_s;
        rx_idx <= rx_end ? 4'd0 : rx_idx + 4'd1;
      end else if (!rx_en) begin
        rx_idx <= '0;
      end
    end else begin
      case (rx_state)
        RX_IDLE: begin
          rx_idx <= '0;
          rx_cnt <= '0;
          if (!rxd_s) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (tick) begin
            if (rx_cnt == HALF_TICKS - 8'd1) begin
              rx_cnt   <= '0;
              rx_state <= rxd_s ? RX_IDLE : RX_DATA;
            end else begin
              rx_cnt <= rx_cnt + 8'd1;
            end
          end
        end
        RX_DATA: begin
          if (tick) begin
            rx_cnt <= (rx_cnt == BIT_TICKS - 8'd1) ? 8'd0 : rx_cnt + 8'd1;
          end
          if (async_take) begin
            rx_bits[rx_idx] <= rxd_s;
            rx_idx <= rx_idx + 4'd1;
            if (rx_end) begin
              rx_state <= RX_IDLE;
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // the bit on the line this cycle completes the frame
  always_comb begin
    logic [11:0] fb;
    fb = rx_bits;
    fb[rx_idx] = rxd_s;
    rx_char    = chr7 ? {1'b0, fb[6:0]} : fb[7:0];
    rx_extra   = fb[rx_data_len];
    rx_frm_err = !sync_mode && !rxd_s;
    rx_par_err = par_on && (parity_of(rx_char, odd_sense) != rx_extra);
  end

  assign rx_push      = rx_end && !rx_frm_err && !rx_par_err;
  assign rxq_in.valid = rx_push;
  assign rxq_in.data  = rx_char;

  standby_clear_a : assert property (@(posedge clk) disable iff (!rst_n)
    standby |=> serial_format_reg == 8'h00 && serial_ctrl_reg == 8'h00)
    else $error("registers not cleared by standby");
  async_start_a : assert property (@(posedge clk) disable iff (!rst_n)
    tx_load && !sync_mode |=> !txd && tx_state == TX_SHIFT)
    else $error("async frame lacks start bit");
  sync_len_a : assert property (@(posedge clk) disable iff (!rst_n)
    tx_load && sync_mode |=> tx_left == 4'd8
    && txd == $past(tx_holding_reg[0]))
    else $error("sync frame not eight bare bits");
  plain_len_a : assert property (@(posedge clk) disable iff (!rst_n)
    tx_load && !sync_mode && serial_format_reg[7:2] == 6'h00
    |=> tx_left == 4'd10)
    else $error("8N1 frame length wrong");
  long_len_a : assert property (@(posedge clk) disable iff (!rst_n)
    tx_load && !sync_mode && serial_format_reg[7:2] == 6'h1a
    |=> tx_left == 4'd11 && tx_shift_reg[10:9] == 2'b11)
    else $error("7-bit parity two-stop frame wrong");
  parity_sense_a : assert property (@(posedge clk) disable iff (!rst_n)
    tx_load && par_on && !chr7
    |=> (^tx_shift_reg[9:1]) == $past(odd_sense))
    else $error("transmitted parity has wrong sense");
  mp_bit_a : assert property (@(posedge clk) disable iff (!rst_n)
    tx_load && mp_fmt && !chr7
    |=> tx_shift_reg[9] == $past(serial_status_reg[ST_MPBT]))
    else $error("multiprocessor bit not sent");
  irq_raise_a : assert property (@(posedge clk) disable iff (!rst_n)
    tx_load && serial_ctrl_reg[CTL_TIE] && !standby
    && !(cpu_wr && cpu_addr == OFS_CTRL) |=> tx_empty_irq)
    else $error("empty request not raised on load");
  irq_drop_a : assert property (@(posedge clk) disable iff (!rst_n)
    $fell(tx_holding_empty_flag) || $fell(serial_ctrl_reg[CTL_TIE]) |-> !tx_empty_irq)
    else $error("empty request not withdrawn");
endmodule
`default_nettype wire

// file: common/serial_cfg_pkg.sv
// constants and types shared by the serial channel and its bench
package serial_cfg_pkg;
  localparam int unsigned CLK_MHZ       = 40;
  localparam logic [2:0]  OFS_FORMAT    = 3'h0;
  localparam logic [2:0]  OFS_CTRL      = 3'h2;
  localparam logic [2:0]  OFS_TXHOLD    = 3'h3;
  localparam logic [2:0]  OFS_STATUS    = 3'h4;
  localparam logic [2:0]  OFS_RXDATA    = 3'h5;
  localparam logic [7:0]  FORMAT_RST    = 8'h00;
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [7:0]  TXHOLD_RST    = 8'hff;
  localparam logic [7:0]  STATUS_RST    = 8'h84;
  localparam logic [7:0]  RDATA_RST     = 8'h00;
  // format register fields
  localparam int unsigned FMT_SYNC      = 7;
  localparam int unsigned FMT_CHR7      = 6;
  localparam int unsigned FMT_PE        = 5;
  localparam int unsigned FMT_ODD       = 4;
  localparam int unsigned FMT_STOP2     = 3;
  localparam int unsigned FMT_MP        = 2;
  localparam int unsigned FMT_CKS_LO    = 0;
  // control register fields
  localparam int unsigned CTL_TIE       = 7;
  localparam int unsigned CTL_RIE       = 6;
  localparam int unsigned CTL_TE        = 5;
  localparam int unsigned CTL_RE        = 4;
  // status register fields
  localparam int unsigned ST_TX_HOLDING_EMPTY_FLAG       = 7;
  localparam int unsigned ST_RDRF       = 6;
  localparam int unsigned ST_ORER       = 5;
  localparam int unsigned ST_FER        = 4;
  localparam int unsigned ST_PER        = 3;
  localparam int unsigned ST_TEND       = 2;
  localparam int unsigned ST_MPB        = 1;
  localparam int unsigned ST_MPBT       = 0;
  localparam logic [7:0]  ST_CLEARABLE  = 8'hb8;
  // prescaled ticks per serial bit, stands in for the bit-rate divider
  localparam logic [7:0]  BIT_TICKS     = 8'd16;
  localparam logic [7:0]  HALF_TICKS    = 8'd8;
  localparam logic [3:0]  LEN_SYNC      = 4'd8;
  localparam int unsigned RXQ_WIDTH     = 8;
  localparam int unsigned RXQ_DEPTH     = 8;
  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rx_state_t;
endpackage

// file: common/stream_if.sv
// valid/ready word stream between the channel and its receive buffer
`timescale 1ns/1ps
`default_nettype none
interface stream_if #(parameter int unsigned WIDTH = 8);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// file: src/stream_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic clk,
  input  wire logic rst_n,
  stream_if.snk     fill,
  stream_if.src     drain
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign fill.ready  = (count != (AW+1)'(DEPTH));
  assign drain.valid = (count != '0);
  assign drain.data  = mem[rptr];
  assign push        = fill.valid && fill.ready;
  assign pop         = drain.valid && drain.ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr] <= fill.data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == AW'(DEPTH-1)) ? '0 : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == AW'(DEPTH-1)) ? '0 : rptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// file: dv/remote_uart.sv
// remote serial peer: samples frames from txd, sends bit strings on rxd
`timescale 1ns/1ps
`default_nettype none
module remote_uart (
  input  wire logic        clk,
  input  wire logic        txd,
  input  wire logic        sck_out,
  input  wire logic [11:0] bit_cyc,
  input  wire logic [3:0]  nbits,
  input  wire logic        send_go,
  input  wire logic [39:0] send_bits,
  input  wire logic [5:0]  send_n,
  output logic             rxd,
  output logic      [11:0] frame,
  output logic      [15:0] period,
  output logic      [7:0]  sck_cnt,
  output logic      [7:0]  sync_word
);
  int now = 0;
  int last = 0;
  initial rxd = 1'b1;
  initial sck_cnt = 8'h00;
  always @(posedge clk) now <= now + 1;
  // samples mid-bit; after the last stop it re-arms at once, so a frame
  // that follows back to back is still caught at its start edge
  always begin
    @(negedge txd);
    period = 16'(now - last);
    last = now;
    frame = '1;
    repeat (bit_cyc / 2) @(negedge clk);
    for (int i = 0; i < nbits; i++) begin
      frame[i] = txd;
      if (i < nbits - 1) repeat (bit_cyc) @(negedge clk);
    end
  end
  always @(posedge sck_out) begin
    sck_cnt <= sck_cnt + 8'h01;
    sync_word <= {txd, sync_word[7:1]};
  end
  // the line idles high between strings, as a marking serial line does
  always @(posedge send_go) begin
    for (int i = 0; i < send_n; i++) begin
      rxd = send_bits[i];
      repeat (bit_cyc) @(negedge clk);
    end
    rxd = 1'b1;
  end
endmodule
`default_nettype wire

// file: dv/serial_format_and_mode_config_tb_top.sv
// self-checking bench for the serial channel format and control registers
`timescale 1ns/1ps
`default_nettype none
module serial_format_and_mode_config_tb_top;
  import serial_cfg_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        standby = 1'b0;
  logic [2:0]  cpu_addr = 3'h0;
  logic        cpu_wr = 1'b0;
  logic        cpu_rd = 1'b0;
  logic [7:0]  cpu_wdata = 8'h00;
  logic [7:0]  cpu_rdata, sck_cnt, sync_word, s, f, b0, b1, b2;
  logic        rxd, txd, sck_out, sck_oe, tx_empty_irq, rx_irq;
  logic [11:0] bit_cyc = 12'd16;
  logic [3:0]  nbits = 4'd1;
  logic        send_go = 1'b0;
  logic [39:0] send_bits = '1;
  logic [5:0]  send_n = 6'd0;
  logic [11:0] frame;
  logic [15:0] period;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          seed = 32'h04c1;
  logic [7:0]  fmts [7] = '{8'h00, 8'h68, 8'h30, 8'h3c, 8'h49, 8'h12, 8'h0b};
  always #12.5 clk = ~clk;
  serial_channel serial_channel_inst (
    .clk(clk), .rst_n(rst_n), .standby(standby), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .rxd(rxd), .txd(txd), .sck_out(sck_out),
    .sck_oe(sck_oe), .tx_empty_irq(tx_empty_irq), .rx_irq(rx_irq));
  remote_uart remote_uart_inst (
    .clk(clk), .txd(txd), .sck_out(sck_out), .bit_cyc(bit_cyc),
    .nbits(nbits), .send_go(send_go), .send_bits(send_bits),
    .send_n(send_n), .rxd(rxd), .frame(frame), .period(period),
    .sck_cnt(sck_cnt), .sync_word(sync_word));
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // worst case is the slowest prescale setting, near 27k cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fail_count = fail_count + 1;
      finish_test();
    end
  end
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge clk);
    cpu_wr = 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge clk);
    cpu_rd = 1'b0;
    @(negedge clk);
    d = cpu_rdata;
  endtask
  task automatic chk(input logic [2:0] a, input logic [7:0] e);
    rd(a, s);
    check("register", s, e);
  endtask
  // the status read arms the clear; bit 0 written 1 sets the mp bit sent
  task automatic clr_tx_holding_empty_flag;
    rd(OFS_STATUS, s);
    wr(OFS_STATUS, 8'h7f);
  endtask
  function automatic int flen(input logic [7:0] g);
    return g[7] ? 8 : 10 - g[6] + (g[2] | g[5]) + g[3];
  endfunction
  function automatic logic [11:0] xf(input logic [7:0] g, input logic [7:0] b);
    logic [7:0]  d;
    logic [11:0] v;
    d = g[6] ? {1'b0, b[6:0]} : b;
    v = g[6] ? {4'hf, d[6:0], 1'b0} : {3'h7, d, 1'b0};
    if (g[2] | g[5]) v[g[6] ? 8 : 9] = g[2] | (^d ^ g[4]);
    return v;
  endfunction
  task automatic send2(input logic [7:0] g);
    b0 = $random(seed);
    b1 = $random(seed);
    bit_cyc = 12'd16 << (2 * g[1:0]);
    nbits = 4'(flen(g));
    wr(OFS_FORMAT, g);
    wr(OFS_CTRL, 8'h20);
    wr(OFS_TXHOLD, b0);
    clr_tx_holding_empty_flag();
    repeat (4) @(negedge clk);
    wr(OFS_TXHOLD, b1);
    clr_tx_holding_empty_flag();
    repeat (26 * bit_cyc) @(negedge clk);
  endtask
  // bad parity with two stops, then a frame whose second stop is a start
  task automatic rx3(input logic [7:0] g);
    b0 = $random(seed);
    b1 = $random(seed);
    b2 = $random(seed);
    bit_cyc = 12'd16;
    wr(OFS_FORMAT, g);
    wr(OFS_CTRL, 8'h10);
    send_n = 6'd34;
    send_bits = {6'h3f, 1'b1, ^b2 ^ g[4], b2, 1'b0, 1'b1, ^b1 ^ g[4], b1,
                 1'b0, 2'b11, ~(^b0 ^ g[4]), b0, 1'b0};
    send_go = 1'b1;
    @(negedge clk) send_go = 1'b0;
    repeat (36 * 16) @(negedge clk);
    rd(OFS_STATUS, s);
    check("parity error", s[ST_PER], 1'b1);
    wr(OFS_CTRL, 8'h50);
    check("rx irq", rx_irq, 1'b1);
    wr(OFS_STATUS, 8'h00);
    chk(OFS_RXDATA, b1);
    chk(OFS_RXDATA, b2);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    chk(OFS_FORMAT, FORMAT_RST);
    chk(OFS_CTRL, CTRL_RST);
    chk(3'h1, 8'h00);
    for (int k = 0; k < 4; k++) begin
      f = $random(seed);
      wr(OFS_FORMAT, f);
      chk(OFS_FORMAT, f);
      wr(OFS_CTRL, f ^ 8'h5a);
      chk(OFS_CTRL, f ^ 8'h5a);
    end
    @(negedge clk) standby = 1'b1;
    @(negedge clk) standby = 1'b0;
    chk(OFS_FORMAT, 8'h00);
    chk(OFS_CTRL, 8'h00);
    wr(OFS_CTRL, 8'h80);
    check("tx irq", tx_empty_irq, 1'b1);
    wr(OFS_CTRL, 8'h00);
    check("tx irq", tx_empty_irq, 1'b0);
    wr(OFS_CTRL, 8'ha0);
    wr(OFS_TXHOLD, 8'h55);
    clr_tx_holding_empty_flag();
    repeat (3) @(negedge clk);
    check("tx irq", tx_empty_irq, 1'b1);
    clr_tx_holding_empty_flag();
    check("tx irq", tx_empty_irq, 1'b0);
    repeat (400) @(negedge clk);
    for (int k = 0; k < 11; k++) begin
      f = (k < 7) ? fmts[k] : 8'($random(seed)) & 8'h7c;
      send2(f);
      check("frame", frame, xf(f, b1));
      // the first bit may be short by up to one prescale period
      check("frame bits", (period + bit_cyc / 2) / bit_cyc, flen(f));
      check("sck oe", sck_oe, 1'b0);
    end
    rx3(8'h28);
    rx3(8'h38);
    b2 = sck_cnt;
    send2(8'hfc);
    check("sck edges", 8'(sck_cnt - b2), 8'd16);
    check("sync word", sync_word, b1);
    check("sck oe", sck_oe, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
